// *** spmic_pkg.sv ***
// Package with register map, field layout and shared types of the serial mode and interrupt block.
// What this block does
// - Decode four-bit operating mode; unlisted codes are reserved.
// - Drive serial clock pin only when clock output set and source internal.
// - Character length from length field, or nine bits when nine-bit select set.
// - Clocked-mode bit selects asynchronous (0) or synchronous (1).
// - Parity field: even, odd, forced 0, forced 1, none, multi-drop.
// - Stop bits: one, one and a half (async only), two.
// - Echo mode routes receive pin to transmit pin; receiver still receives.
// - Local loopback feeds transmitter output into receiver input.
// - Remote loopback ties receive pin to transmit pin; 00 is normal.
// - Bit-order bit selects LSB first or MSB first both ways.
// - Oversampling bit selects sixteen-times or eight-times sampling.
// - Inhibit bit set means no negative acknowledge is ever sent.
// - Successive-disable clear: negative acknowledge after every parity error in smart-card T=0 mode.
// - Successive-disable set: count errors, stop at limit, set iteration flag.
// - Maximum-iteration field limits repetitions in smart-card T=0.
// - Infrared filter: two-of-three majority over three sub-bit samples.
// - Enable-register write sets mask bits written one.
// - Disable-register write clears mask bits written one.
// - Enable and disable registers share one source bit map.
// - Readable mask, reset to zero, changed only by enable and disable.
// - Modem-line change flags set on level change, cleared on status read.
package spmic_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_IER = 8'h08;
   localparam logic [7:0] ADDR_IDR = 8'h0c;
   localparam logic [7:0] ADDR_IMR = 8'h10;
   localparam logic [7:0] ADDR_CSR = 8'h14;
   localparam logic [7:0] ADDR_CNT = 8'h44;

   // ----------------------------------------
   // Reset values and masks
   // ----------------------------------------
   localparam logic [31:0] MODE_RESET = 32'h0000_0000;
   localparam logic [31:0] MODE_WMASK = 32'h173f_ffff;
   localparam logic [31:0] IRQ_MAP = 32'h000f_3fff;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;

   // ----------------------------------------
   // Source bit positions
   // ----------------------------------------
   localparam int SRC_PARITY_ERROR_FLAG = 7;
   localparam int SRC_ITER = 10;
   localparam int SRC_NEGATIVE_ACK_FLAG = 13;
   localparam int SRC_RING_CHANGE_FLAG = 16;

   // ----------------------------------------
   // Field codes
   // ----------------------------------------
   localparam logic [3:0] OPM_NORMAL = 4'h0;
   localparam logic [3:0] OPM_RS485 = 4'h1;
   localparam logic [3:0] OPM_HSHAKE = 4'h2;
   localparam logic [3:0] OPM_MODEM = 4'h3;
   localparam logic [3:0] OPM_CARD_T0 = 4'h4;
   localparam logic [3:0] OPM_CARD_T1 = 4'h6;
   localparam logic [3:0] OPM_IRDA = 4'h8;
   localparam logic [1:0] CLK_MASTER = 2'h0;
   localparam logic [1:0] CLK_DIVIDED = 2'h1;
   localparam logic [1:0] CLK_PIN = 2'h3;
   localparam logic [1:0] LOOP_NORMAL = 2'h0;
   localparam logic [1:0] LOOP_ECHO = 2'h1;
   localparam logic [1:0] LOOP_LOCAL = 2'h2;
   localparam logic [1:0] LOOP_REMOTE = 2'h3;
   localparam logic [3:0] LEN_NINE = 4'h9;
   localparam logic [3:0] LEN_BASE = 4'h5;
   localparam logic [4:0] OVS_SIXTEEN = 5'h10;
   localparam logic [4:0] OVS_EIGHT = 5'h08;

   typedef enum logic [2:0] {
      spmic_par_even, spmic_par_odd, spmic_par_space, spmic_par_mark, spmic_par_none, spmic_par_multidrop
   } spmic_par_e;

   typedef enum logic [1:0] {
      spmic_stop_one, spmic_stop_one_half, spmic_stop_two, spmic_stop_bad
   } spmic_stop_e;

   // Mode register layout, bit 31 down to bit 0.
   typedef struct packed {
      logic [2:0] rsv31;
      logic filter;
      logic rsv27;
      logic [2:0] max_iteration;
      logic [1:0] rsv23;
      logic successive_negack_disable;
      logic negative_ack_inhibit;
      logic oversample;
      logic clock_output_drive;
      logic nine_bit_select;
      logic bit_order;
      logic [1:0] loop_config;
      logic [1:0] stop_bit_count;
      logic [2:0] parity_kind;
      logic sync_select;
      logic [1:0] char_length_field;
      logic [1:0] bit_clock_source;
      logic [3:0] op_mode;
   } spmic_mode_s;

   // Decoded configuration handed to the shifters.
   typedef struct packed {
      logic [3:0] op_mode;
      logic mode_reserved;
      logic [1:0] clk_sel;
      logic [3:0] char_bits;
      logic sync_mode;
      spmic_par_e parity;
      spmic_stop_e stop;
      logic msb_first;
      logic [4:0] oversample_ratio;
      logic card_t0;
      logic irda;
   } spmic_cfg_s;

   // Status events from the shifters.
   typedef struct packed {
      logic [12:0] events;
      logic parity_err_char;
      logic [3:0] modem_lines;
   } spmic_evt_s;

endpackage

// *** spmic_core.sv ***
// Mode register, interrupt mask, modem change flags, loop routing, filter and negative-acknowledge control.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
module spmic_core #(
   parameter int ITER_W = 3
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Status from shifters
   input wire spmic_pkg::spmic_evt_s evt,
   input wire logic char_done,
   input wire logic sample_tick,
   // Line side
   input wire logic rx_pin,
   input wire logic tx_shift_out,
   input wire logic clk_master,
   input wire logic clk_divided,
   input wire logic sck_in,
   output logic tx_pin,
   output logic rx_to_receiver,
   output logic sck_out,
   output logic sck_oe,
   output logic bit_clock,
   output logic negack_send,
   // Configuration and interrupt
   output spmic_pkg::spmic_cfg_s cfg,
   output logic irq
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [31:0] mode;
      logic [31:0] mask;
      logic [3:0] change;
      logic [3:0] lines_prev;
      logic iter_flag;
      logic negative_ack_flag_flag;
      logic [ITER_W-1:0] err_count;
      logic [2:0] filt_hist;
      logic filt_out;
      logic negack;
      logic [31:0] rdata;
   } spmic_state_s;

   spmic_state_s st;
   spmic_state_s next_st;
   spmic_pkg::spmic_mode_s m;
   logic [31:0] status;
   logic rx_line;
   logic [ITER_W-1:0] iter_limit;
   logic parity_hit;

   function automatic logic majority(input logic [2:0] s);
      majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   assign m = spmic_pkg::spmic_mode_s'(st.mode);
   assign iter_limit = m.max_iteration[ITER_W-1:0];

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   always_comb begin
      cfg.op_mode = m.op_mode;
      case (m.op_mode)
         spmic_pkg::OPM_NORMAL, spmic_pkg::OPM_RS485, spmic_pkg::OPM_HSHAKE, spmic_pkg::OPM_MODEM,
         spmic_pkg::OPM_CARD_T0, spmic_pkg::OPM_CARD_T1, spmic_pkg::OPM_IRDA: cfg.mode_reserved = 1'b0;
         default: cfg.mode_reserved = 1'b1;
      endcase
      cfg.clk_sel = m.bit_clock_source;
      cfg.char_bits = m.nine_bit_select ? spmic_pkg::LEN_NINE
                      : spmic_pkg::LEN_BASE + {2'h0, m.char_length_field};
      cfg.sync_mode = m.sync_select;
      case (m.parity_kind)
         3'h0: cfg.parity = spmic_pkg::spmic_par_even;
         3'h1: cfg.parity = spmic_pkg::spmic_par_odd;
         3'h2: cfg.parity = spmic_pkg::spmic_par_space;
         3'h3: cfg.parity = spmic_pkg::spmic_par_mark;
         3'h4, 3'h5: cfg.parity = spmic_pkg::spmic_par_none;
         default: cfg.parity = spmic_pkg::spmic_par_multidrop;
      endcase
      case (m.stop_bit_count)
         2'h0: cfg.stop = spmic_pkg::spmic_stop_one;
         2'h1: cfg.stop = m.sync_select ? spmic_pkg::spmic_stop_bad : spmic_pkg::spmic_stop_one_half;
         2'h2: cfg.stop = spmic_pkg::spmic_stop_two;
         default: cfg.stop = spmic_pkg::spmic_stop_bad;
      endcase
      cfg.msb_first = m.bit_order;
      cfg.oversample_ratio = m.oversample ? spmic_pkg::OVS_EIGHT : spmic_pkg::OVS_SIXTEEN;
      cfg.card_t0 = (m.op_mode == spmic_pkg::OPM_CARD_T0);
      cfg.irda = (m.op_mode == spmic_pkg::OPM_IRDA);
   end

   // ----------------------------------------
   // Clock selection and pin routing
   // ----------------------------------------
   // Reserved clock code falls back to the master clock; software must avoid it.
   always_comb begin
      case (m.bit_clock_source)
         spmic_pkg::CLK_DIVIDED: bit_clock = clk_divided;
         spmic_pkg::CLK_PIN: bit_clock = sck_in;
         default: bit_clock = clk_master;
      endcase
   end

   assign sck_oe = m.clock_output_drive & (m.bit_clock_source != spmic_pkg::CLK_PIN);
   assign sck_out = sck_oe & bit_clock;

   // The filter only makes sense on the sixteenth-bit sample strobe.
   assign rx_line = m.filter ? st.filt_out : rx_pin;

   always_comb begin
      case (m.loop_config)
         spmic_pkg::LOOP_ECHO: begin
            tx_pin = rx_pin;
            rx_to_receiver = rx_line;
         end
         spmic_pkg::LOOP_LOCAL: begin
            tx_pin = 1'b1;
            rx_to_receiver = tx_shift_out;
         end
         spmic_pkg::LOOP_REMOTE: begin
            tx_pin = rx_pin;
            rx_to_receiver = 1'b1;
         end
         default: begin
            tx_pin = tx_shift_out;
            rx_to_receiver = rx_line;
         end
      endcase
   end

   // ----------------------------------------
   // Status and interrupt
   // ----------------------------------------
   always_comb begin
      status = 32'h0;
      status[12:0] = evt.events;
      status[spmic_pkg::SRC_ITER] = st.iter_flag;
      status[spmic_pkg::SRC_NEGATIVE_ACK_FLAG] = st.negative_ack_flag_flag;
      status[19:16] = st.change;
      status[23:20] = evt.modem_lines;
   end

   assign irq = |(status & st.mask & spmic_pkg::IRQ_MAP);
   assign parity_hit = char_done & evt.parity_err_char & cfg.card_t0;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_st.negack = 1'b0;
      next_st.rdata = 32'h0;
      next_st.lines_prev = evt.modem_lines;
      if (reg_wr) begin
         case (reg_addr)
            spmic_pkg::ADDR_MODE: next_st.mode = reg_wdata & spmic_pkg::MODE_WMASK;
            spmic_pkg::ADDR_IER: next_st.mask = st.mask | (reg_wdata & spmic_pkg::IRQ_MAP);
            spmic_pkg::ADDR_IDR: next_st.mask = st.mask & ~(reg_wdata & spmic_pkg::IRQ_MAP);
            default: next_st.mask = st.mask;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            spmic_pkg::ADDR_MODE: next_st.rdata = st.mode;
            spmic_pkg::ADDR_IMR: next_st.rdata = st.mask;
            spmic_pkg::ADDR_CSR: begin
               next_st.rdata = status;
               next_st.change = 4'h0;
               next_st.iter_flag = st.iter_flag;
            end
            spmic_pkg::ADDR_CNT: next_st.rdata = {{(32-ITER_W){1'b0}}, st.err_count};
            default: next_st.rdata = 32'h0;
         endcase
      end
      // A change in the read cycle wins over the clear.
      next_st.change = next_st.change | (evt.modem_lines ^ st.lines_prev);
      if (sample_tick) begin
         next_st.filt_hist = {st.filt_hist[1:0], rx_pin};
         next_st.filt_out = majority({st.filt_hist[1:0], rx_pin});
      end
      if (char_done & ~evt.parity_err_char) begin
         next_st.err_count = '0;
      end
      if (parity_hit & ~m.negative_ack_inhibit) begin
         if (~m.successive_negack_disable) begin
            next_st.negack = 1'b1;
            next_st.negative_ack_flag_flag = 1'b1;
         end else if (st.err_count < iter_limit) begin
            next_st.negack = 1'b1;
            next_st.negative_ack_flag_flag = 1'b1;
            next_st.err_count = st.err_count + 1'b1;
            if (st.err_count + 1'b1 == iter_limit) begin
               next_st.iter_flag = 1'b1;
            end
         end else begin
            next_st.iter_flag = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{mode: spmic_pkg::MODE_RESET, mask: spmic_pkg::MASK_RESET, filt_hist: 3'h7, filt_out: 1'b1,
                 default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign negack_send = st.negack;

endmodule

// *** spmic_assertions.sv ***
// Checker for mode decode, loop routing and interrupt mask of the serial mode block.
`timescale 1ns/10ps
module spmic_assertions (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Status, line side and decode
   input wire spmic_pkg::spmic_evt_s evt,
   input wire logic rx_pin,
   input wire logic tx_shift_out,
   input wire logic tx_pin,
   input wire logic rx_to_receiver,
   input wire logic sck_oe,
   input wire logic negack_send,
   input wire spmic_pkg::spmic_cfg_s cfg,
   input wire logic irq
);
   // ----------------------------------------
   // Shadow registers
   // ----------------------------------------
   // Clock-output, oversampling and acknowledge bits are real fields, so they must be writable.
   logic [31:0] md;
   logic [31:0] msk;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         md <= 32'h0;
         msk <= 32'h0;
      end else if (reg_wr && reg_addr == spmic_pkg::ADDR_MODE) begin
         md <= reg_wdata & 32'h173f_ffff;
      end else if (reg_wr && reg_addr == spmic_pkg::ADDR_IER) begin
         msk <= msk | (reg_wdata & 32'h000f_3fff);
      end else if (reg_wr && reg_addr == spmic_pkg::ADDR_IDR) begin
         msk <= msk & ~reg_wdata;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_mask_rd; reg_rd && reg_addr == spmic_pkg::ADDR_IMR |=> reg_rdata == $past(msk); endproperty
   a_mask_rd: assert property (p_mask_rd) else $error("mask read mismatch");
   property p_sck; sck_oe == (md[18] && md[5:4] != 2'h3); endproperty
   a_sck: assert property (p_sck) else $error("clock pin enable mismatch");
   property p_len; cfg.char_bits == (md[17] ? 4'h9 : 4'h5 + {2'h0, md[7:6]}); endproperty
   a_len: assert property (p_len) else $error("char length mismatch");
   property p_echo; md[15:14] == 2'h1 && !md[28] |-> tx_pin == rx_pin && rx_to_receiver == rx_pin; endproperty
   a_echo: assert property (p_echo) else $error("echo routing mismatch");
   property p_local; md[15:14] == 2'h2 |-> rx_to_receiver == tx_shift_out && tx_pin; endproperty
   a_local: assert property (p_local) else $error("local loop mismatch");
   property p_remote; md[15:14] == 2'h3 |-> tx_pin == rx_pin; endproperty
   a_remote: assert property (p_remote) else $error("remote loop mismatch");
   property p_irq; (msk[12:0] & evt.events & 13'h1bff) != 13'h0 |-> irq; endproperty
   a_irq: assert property (p_irq) else $error("enabled source without request");
   property p_inhibit; md[20] && $past(md[20], 2) |-> !negack_send; endproperty
   a_inhibit: assert property (p_inhibit) else $error("negative ack while inhibited");
   c_remote: cover property (md[15:14] == 2'h3 && !rx_pin);
   c_irq: cover property (irq ##1 !irq);
   c_negack: cover property (negack_send);
endmodule
bind spmic_core spmic_assertions u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt),
   .rx_pin(rx_pin), .tx_shift_out(tx_shift_out), .tx_pin(tx_pin), .rx_to_receiver(rx_to_receiver),
   .sck_oe(sck_oe), .negack_send(negack_send), .cfg(cfg), .irq(irq));

// *** spmic_line_model.sv ***
// Far-side line partner: receive line, modem status lines and external serial clock.
`timescale 1ns/10ps
module spmic_line_model (
   // Clock
   input wire logic clk_sys,
   // Scenario controls
   input wire logic rx_lvl,
   input wire logic [3:0] lines,
   input wire logic sck_run,
   // Line side
   output logic rx_pin = 1'b1,
   output logic [3:0] modem = 4'h0,
   output logic sck_in = 1'b0
);
   // The external clock stands still between frames, as a real terminal's would.
   always @(posedge clk_sys) begin
      rx_pin <= rx_lvl;
      modem <= lines;
      sck_in <= sck_run ? ~sck_in : 1'b0;
   end
endmodule

// *** tb_serial_port_mode_and_irq_config.sv ***
// Self-checking testbench of the serial mode and interrupt block.
`timescale 1ns/10ps
module tb_serial_port_mode_and_irq_config;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [12:0] events = 13'h0;
   logic perr = 1'b0;
   logic char_done = 1'b0;
   logic tx_shift_out = 1'b1;
   logic rx_lvl = 1'b1;
   logic [3:0] lines = 4'h0;
   logic sck_run = 1'b0;
   logic [1:0] div = 2'h0;
   logic [3:0] modem;
   logic [31:0] reg_rdata;
   logic rx_pin, sck_in, tx_pin, rx_to_receiver, sck_out, sck_oe, bit_clock, negack_send, irq, seen;
   spmic_pkg::spmic_evt_s evt;
   spmic_pkg::spmic_cfg_s cfg;
   int bad_count = 0;
   int checked = 0;
   assign evt = {events, perr, modem};
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   // One counter gives both the divided clock and the sub-bit strobe, so they stay in step.
   always @(posedge clk_sys) div <= div + 2'h1;
   spmic_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .char_done(char_done),
      .sample_tick(div == 2'h0), .rx_pin(rx_pin), .tx_shift_out(tx_shift_out), .clk_master(clk_sys),
      .clk_divided(div[1]), .sck_in(sck_in), .tx_pin(tx_pin), .rx_to_receiver(rx_to_receiver),
      .sck_out(sck_out), .sck_oe(sck_oe), .bit_clock(bit_clock), .negack_send(negack_send), .cfg(cfg), .irq(irq));
   spmic_line_model partner (.clk_sys(clk_sys), .rx_lvl(rx_lvl), .lines(lines), .sck_run(sck_run),
      .rx_pin(rx_pin), .modem(modem), .sck_in(sck_in));
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(nm, exp, reg_rdata);
   endtask
   task automatic stop_test;
      if (bad_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      rd(spmic_pkg::ADDR_IMR, 32'h0, "mask");
      wr(spmic_pkg::ADDR_IER, 32'hffff_ffff);
      rd(spmic_pkg::ADDR_IMR, 32'h000f_3fff, "mask");
      wr(spmic_pkg::ADDR_IDR, 32'h0000_00f0);
      wr(spmic_pkg::ADDR_IER, 32'h0);
      rd(spmic_pkg::ADDR_IMR, 32'h000f_3f0f, "mask");
      rd(8'h30, 32'h0, "unmapped");
      wr(spmic_pkg::ADDR_IDR, 32'hffff_ffff);
      rd(spmic_pkg::ADDR_IMR, 32'h0, "mask");
   endtask
   task automatic t_mode;
      logic [3:0] ops [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
      foreach (ops[i]) begin
         wr(spmic_pkg::ADDR_MODE, {28'h0, ops[i]});
         chk("op_mode", {28'h0, ops[i]}, {28'h0, cfg.op_mode});
         chk("reserved", 0, cfg.mode_reserved);
      end
      for (int k = 0; k < 8; k++) begin
         wr(spmic_pkg::ADDR_MODE, 32'(k % 3) << 12 | 32'(k) << 9);
         chk("parity", k[2] ? 4 + k[1] : k, 32'(cfg.parity));
         chk("stop", k % 3, 32'(cfg.stop));
      end
      wr(spmic_pkg::ADDR_MODE, 32'hffff_cfc0);
      rd(spmic_pkg::ADDR_MODE, 32'h173f_cfc0, "mode");
      chk("len", 9, cfg.char_bits);
      chk("ratio", 8, cfg.oversample_ratio);
      chk("order", 1, cfg.msb_first);
      chk("sync", 1, cfg.sync_mode);
      wr(spmic_pkg::ADDR_MODE, 32'h0000_00c0);
      chk("len", 8, cfg.char_bits);
      chk("ratio", 16, cfg.oversample_ratio);
   endtask
   task automatic t_clock;
      @(posedge clk_sys);
      sck_run <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         if (s == 2) continue;
         wr(spmic_pkg::ADDR_MODE, 32'h0004_0000 | 32'(s) << 4);
         chk("sck_oe", s != 3, sck_oe);
         repeat (2) begin
            @(posedge clk_sys);
            #1;
            chk("bit_clock", s == 3 ? sck_in : s == 1 ? div[1] : clk_sys, bit_clock);
            chk("sck_out", s == 3 ? 1'b0 : s == 1 ? div[1] : clk_sys, sck_out);
         end
      end
      wr(spmic_pkg::ADDR_MODE, 32'h0);
      sck_run <= 1'b0;
      chk("sck_oe", 0, sck_oe);
   endtask
   task automatic t_loop;
      for (int m = 0; m < 4; m++) begin
         wr(spmic_pkg::ADDR_MODE, 32'(m) << 14);
         for (int v = 0; v < 4; v++) begin
            @(posedge clk_sys);
            rx_lvl <= v[0];
            tx_shift_out <= v[1];
            repeat (2) @(posedge clk_sys);
            #1;
            chk("tx_pin", m == 0 ? v[1] : m == 2 ? 1 : v[0], tx_pin);
            chk("rx_in", m == 2 ? v[1] : m == 3 ? 1 : v[0], rx_to_receiver);
         end
      end
   endtask
   task automatic t_irq;
      wr(spmic_pkg::ADDR_IER, 32'h0001_0001);
      @(posedge clk_sys);
      events <= 13'h0001;
      #1;
      chk("irq", 1, irq);
      wr(spmic_pkg::ADDR_IDR, 32'h0000_0001);
      chk("irq", 0, irq);
      @(posedge clk_sys);
      events <= 13'h0;
      lines <= 4'h1;
      repeat (6) @(posedge clk_sys);
      chk("irq", 1, irq);
      rd(spmic_pkg::ADDR_CSR, 32'h0011_0000, "status");
      chk("irq", 0, irq);
      wr(spmic_pkg::ADDR_IDR, 32'hffff_ffff);
   endtask
   task automatic bad_char(input logic [31:0] mode, output logic s);
      wr(spmic_pkg::ADDR_MODE, mode);
      @(posedge clk_sys);
      perr <= 1'b1;
      char_done <= 1'b1;
      @(posedge clk_sys);
      perr <= 1'b0;
      char_done <= 1'b0;
      s = 1'b0;
      repeat (4) begin
         #1 s = s | negack_send;
         @(posedge clk_sys);
      end
   endtask
   task automatic t_filter;
      wr(spmic_pkg::ADDR_MODE, 32'h1000_0000);
      @(posedge clk_sys);
      rx_lvl <= 1'b0;
      repeat (16) @(posedge clk_sys);
      #1;
      chk("filtered", 0, rx_to_receiver);
      @(posedge clk_sys);
      rx_lvl <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk("filtered", 0, rx_to_receiver);
      repeat (16) @(posedge clk_sys);
      #1;
      chk("filtered", 1, rx_to_receiver);
   endtask
   // Limit of two repetitions: two acknowledges, the second setting the iteration flag, then silence.
   task automatic t_iter;
      logic s;
      bad_char(32'h0220_0004, s);
      chk("negack", 1, s);
      bad_char(32'h0220_0004, s);
      chk("negack", 1, s);
      rd(spmic_pkg::ADDR_CNT, 32'h2, "errors");
      bad_char(32'h0220_0004, s);
      chk("negack", 0, s);
      rd(spmic_pkg::ADDR_CSR, 32'h0010_2400, "status");
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs();
      t_mode();
      t_clock();
      t_loop();
      t_irq();
      t_filter();
      bad_char(32'h0000_0004, seen);
      chk("negack", 1, seen);
      bad_char(32'h0010_0004, seen);
      chk("negack", 0, seen);
      t_iter();
      stop_test();
   end
   initial begin
      #200us bad_count++;
      stop_test();
   end
endmodule
